// *** rtl/cnt_pwm_pkg.sv ***
// constants for the counter pwm and capture block
// Summary of operation
// - pwm low enable drives port b pin zero
// - pwm high enable drives port b pin one
// - pwm counters always count down
// - pwm counters raise no interrupts or events
// - pwm underflow reloads 0xff or 0xffff
// - wave low above code, high otherwise
// - single counter pwm is eight bits
// - pair size field selects 16/14/12/10 bits
// - code above resolution keeps wave high
// - period two to resolution, duty code-proportional
// - capture active reads of a and b return shadow registers, c and d stay live
// - interrupt after shadow register update
// - a and b share one capture condition
// - capture counters wrap either direction
// - edge field: off, rise, fall, both
// - source field: 1k, 32k, pin three, two
// - capture interrupt one or two ticks late
// - read each shadow after own interrupt
// - capture latching independent for a, b
package cnt_pwm_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CNT_A = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_CNT_B = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_CNT_C = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_CNT_D = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG_FIRST = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG_SECOND = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_PORT_B_OUT = 3'h7;
	// counter_config_first fields
	localparam int CF1_PIN_EN_LSB = 0;
	localparam int CF1_CASC_LSB = 2;
	localparam int CF1_RUN_LSB = 4;
	// counter_config_second fields
	localparam int CF2_RES_FIRST_LSB = 0;
	localparam int CF2_RES_SECOND_LSB = 2;
	localparam int CF2_EDGE_LSB = 4;
	localparam int CF2_SRC_LSB = 6;
	localparam logic [DATA_W-1:0] RESET_CONFIG = 8'h00;
	localparam logic [DATA_W-1:0] RESET_COUNTER = 8'hff;
	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} capture_edge_t;
	typedef enum logic [1:0] {
		SRC_PIN_TWO = 2'b00,
		SRC_PIN_THREE = 2'b01,
		SRC_TAP_32K = 2'b10,
		SRC_TAP_1K = 2'b11
	} capture_source_t;
	localparam logic [15:0] RES_MASK_16 = 16'hffff;
	localparam logic [15:0] RES_MASK_14 = 16'h3fff;
	localparam logic [15:0] RES_MASK_12 = 16'h0fff;
	localparam logic [15:0] RES_MASK_10 = 16'h03ff;
endpackage

// *** rtl/counter_pwm_capture.sv ***
// four 8-bit counters with pwm outputs and a/b capture shadows
`timescale 1ns/10ps
module counter_pwm_capture
	import cnt_pwm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [3:0] count_tick,
	input wire logic tap_1k,
	input wire logic tap_32k,
	input wire logic port_a_pin_two,
	input wire logic port_a_pin_three,
	output logic port_b_pin_zero,
	output logic port_b_pin_one,
	output logic counter_first_interrupt,
	output logic counter_second_interrupt
);

	logic [DATA_W-1:0] cnt_q [4];
	logic [DATA_W-1:0] code_q [4];
	logic [DATA_W-1:0] counter_config_first_q;
	logic [DATA_W-1:0] counter_config_second_q;
	logic [3:0] count_direction_bit_q;
	logic [DATA_W-1:0] port_b_output_value_q;
	logic [DATA_W-1:0] reg_rdata_q;
	logic [DATA_W-1:0] shadow_q [2];
	logic [1:0] pending_q;
	logic [1:0] irq_q;
	logic pin_zero_q;
	logic pin_one_q;
	logic [1:0] pa_meta_q;
	logic [1:0] pa_sync_q;
	logic src_prev_q;

	logic [3:0] step;
	logic [3:0] count_up;
	logic [3:0] wr_cnt;
	logic [1:0] wave;
	logic [1:0] pair_pwm;
	logic [1:0] pair_casc;
	logic [3:0] run;
	logic [1:0] res_first;
	logic [1:0] res_second;
	capture_edge_t capture_edge_select;
	capture_source_t capture_source_select;
	logic capture_active;
	logic src_now;
	logic src_rise;
	logic src_fall;
	logic capture_cond;
	logic [1:0] capture_take;
	logic [DATA_W-1:0] rd_mux;

	function automatic logic [15:0] res_mask(input logic [1:0] sel);
		case (sel)
			2'b11: res_mask = RES_MASK_16;
			2'b10: res_mask = RES_MASK_14;
			2'b01: res_mask = RES_MASK_12;
			default: res_mask = RES_MASK_10;
		endcase
	endfunction

	assign pair_pwm = counter_config_first_q[CF1_PIN_EN_LSB +: 2];
	assign pair_casc = counter_config_first_q[CF1_CASC_LSB +: 2];
	assign run = counter_config_first_q[CF1_RUN_LSB +: 4];
	assign res_first = counter_config_second_q[CF2_RES_FIRST_LSB +: 2];
	assign res_second = counter_config_second_q[CF2_RES_SECOND_LSB +: 2];
	assign capture_edge_select = capture_edge_t'(counter_config_second_q[CF2_EDGE_LSB +: 2]);
	assign capture_source_select = capture_source_t'(counter_config_second_q[CF2_SRC_LSB +: 2]);
	assign capture_active = (capture_edge_select != EDGE_OFF);

	// counter stepping, wave generation per pair
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pair
			localparam int LO = 2 * p;
			localparam int HI = 2 * p + 1;
			logic lo_wrap;
			logic [15:0] pair_val;
			logic [15:0] pair_code;
			logic [15:0] mask;
			logic single_wave;
			logic casc_wave;
			assign step[LO] = count_tick[LO] & run[LO];
			// pwm forces down counting regardless of direction bit
			assign count_up[LO] = count_direction_bit_q[LO] & ~pair_pwm[p];
			assign count_up[HI] = (pair_casc[p] ? count_direction_bit_q[LO] : count_direction_bit_q[HI])
				& ~pair_pwm[p];
			assign lo_wrap = count_up[LO] ? (cnt_q[LO] == 8'hff) : (cnt_q[LO] == 8'h00);
			// cascaded high half steps on the low half carry or borrow, giving 0xffff wrap
			assign step[HI] = pair_casc[p] ? (step[LO] & lo_wrap) : (count_tick[HI] & run[HI]);
			assign pair_val = {cnt_q[HI], cnt_q[LO]};
			assign pair_code = {code_q[HI], code_q[LO]};
			assign mask = res_mask(p == 0 ? res_first : res_second);
			assign single_wave = (cnt_q[LO] <= code_q[LO]);
			// low bits repeat every 2^res counts, so the period follows the resolution
			assign casc_wave = (pair_code > mask) | ((pair_val & mask) <= pair_code);
			assign wave[p] = pair_casc[p] ? casc_wave : single_wave;
		end
	endgenerate

	genvar c;
	generate
		for (c = 0; c < 4; c++) begin : g_cnt
			assign wr_cnt[c] = reg_wr & (reg_addr == ADDR_W'(c));
			always_ff @(posedge core_clk) begin
				if (rst) begin
					cnt_q[c] <= RESET_COUNTER;
					code_q[c] <= RESET_COUNTER;
				end else begin
					if (wr_cnt[c])
						code_q[c] <= reg_wdata;
					// a write reloads the count only while the pair's low counter (a for a/b, c for c/d) is stopped
					if (wr_cnt[c] && !run[c & 2'h2])
						cnt_q[c] <= reg_wdata;
					else if (step[c])
						cnt_q[c] <= count_up[c] ? cnt_q[c] + 8'h01 : cnt_q[c] - 8'h01;
				end
			end
		end
	endgenerate

	// configuration registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			counter_config_first_q <= RESET_CONFIG;
			counter_config_second_q <= RESET_CONFIG;
			count_direction_bit_q <= 4'h0;
			port_b_output_value_q <= RESET_CONFIG;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_CONFIG_FIRST: counter_config_first_q <= reg_wdata;
				ADDR_CONFIG_SECOND: counter_config_second_q <= reg_wdata;
				ADDR_DIRECTION: count_direction_bit_q <= reg_wdata[3:0];
				ADDR_PORT_B_OUT: port_b_output_value_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// port b pins: pwm waveform takes over from the port output bits
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_zero_q <= 1'b0;
			pin_one_q <= 1'b0;
		end else begin
			pin_zero_q <= pair_pwm[0] ? wave[0] : port_b_output_value_q[0];
			pin_one_q <= pair_pwm[1] ? wave[1] : port_b_output_value_q[1];
		end
	end
	assign port_b_pin_zero = pin_zero_q;
	assign port_b_pin_one = pin_one_q;

	// port a capture inputs into the core clock domain
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pa_meta_q <= 2'b00;
			pa_sync_q <= 2'b00;
		end else begin
			pa_meta_q <= {port_a_pin_three, port_a_pin_two};
			pa_sync_q <= pa_meta_q;
		end
	end

	always_comb begin
		case (capture_source_select)
			SRC_TAP_1K: src_now = tap_1k;
			SRC_TAP_32K: src_now = tap_32k;
			SRC_PIN_THREE: src_now = pa_sync_q[1];
			SRC_PIN_TWO: src_now = pa_sync_q[0];
			default: src_now = 1'b0;
		endcase
	end

	assign src_rise = src_now & ~src_prev_q;
	assign src_fall = ~src_now & src_prev_q;

	always_comb begin
		case (capture_edge_select)
			EDGE_RISE: capture_cond = src_rise;
			EDGE_FALL: capture_cond = src_fall;
			EDGE_BOTH: capture_cond = src_rise | src_fall;
			default: capture_cond = 1'b0;
		endcase
	end

	// each counter latches its pending capture on its own counter clock tick
	assign capture_take = pending_q & step[1:0];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			src_prev_q <= 1'b0;
			pending_q <= 2'b00;
			irq_q <= 2'b00;
			shadow_q[0] <= RESET_COUNTER;
			shadow_q[1] <= RESET_COUNTER;
		end else begin
			src_prev_q <= src_now;
			// a new condition in the capture cycle stays pending
			pending_q <= (pending_q & ~capture_take) | {2{capture_cond}};
			if (capture_take[0])
				shadow_q[0] <= cnt_q[0];
			if (capture_take[1])
				shadow_q[1] <= cnt_q[1];
			// interrupt once the shadow holds the new value; pwm pair stays silent
			irq_q <= capture_take & {2{~pair_pwm[0]}};
		end
	end
	assign counter_first_interrupt = irq_q[0];
	assign counter_second_interrupt = irq_q[1];

	// read path, data valid the cycle after the strobe
	always_comb begin
		case (reg_addr)
			ADDR_CNT_A: rd_mux = capture_active ? shadow_q[0] : cnt_q[0];
			ADDR_CNT_B: rd_mux = capture_active ? shadow_q[1] : cnt_q[1];
			ADDR_CNT_C: rd_mux = cnt_q[2];
			ADDR_CNT_D: rd_mux = cnt_q[3];
			ADDR_CONFIG_FIRST: rd_mux = counter_config_first_q;
			ADDR_CONFIG_SECOND: rd_mux = counter_config_second_q;
			ADDR_DIRECTION: rd_mux = {4'h0, count_direction_bit_q};
			ADDR_PORT_B_OUT: rd_mux = port_b_output_value_q;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			reg_rdata_q <= 8'h00;
		else if (reg_rd)
			reg_rdata_q <= rd_mux;
	end
	assign reg_rdata = reg_rdata_q;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_pin_zero_override: assert property (
		pair_pwm[0] |=> port_b_pin_zero == $past(wave[0]))
		else $error("pin zero does not follow pwm wave");
	a_pin_one_override: assert property (
		pair_pwm[1] |=> port_b_pin_one == $past(wave[1]))
		else $error("pin one does not follow pwm wave");
	a_pwm_count_down: assert property (
		pair_pwm[0] && step[0] && !wr_cnt[0] |=> cnt_q[0] == $past(cnt_q[0]) - 8'h01)
		else $error("pwm counter did not decrement");
	a_pwm_no_irq: assert property (
		pair_pwm[0] && $past(pair_pwm[0]) |-> !counter_first_interrupt && !counter_second_interrupt)
		else $error("interrupt raised in pwm mode");
	a_pwm_wrap_full: assert property (
		pair_pwm[0] && !pair_casc[0] && step[0] && !wr_cnt[0] && cnt_q[0] == 8'h00 |=> cnt_q[0] == 8'hff)
		else $error("pwm underflow did not reload 0xff");
	a_wave_compare: assert property (
		!pair_casc[0] && cnt_q[0] > code_q[0] |-> !wave[0])
		else $error("wave high above duty code");
	a_code_over_range: assert property (
		pair_casc[0] && res_first == 2'b00 && {code_q[1], code_q[0]} > RES_MASK_10 |-> wave[0])
		else $error("out of range code did not hold wave high");
	a_capture_irq_data: assert property (
		counter_first_interrupt |-> shadow_q[0] == $past(cnt_q[0]) && $past(pending_q[0]))
		else $error("capture interrupt without shadow update");
	a_capture_edge_off: assert property (
		capture_edge_select == EDGE_OFF && !pending_q[0] |=> !pending_q[0])
		else $error("capture pending while disabled");
	a_capture_latency: assert property (
		capture_cond && !pending_q[0] && run[0] ##1 count_tick[0] |=> counter_first_interrupt || pair_pwm[0])
		else $error("capture interrupt late");
	a_sync_stage: assert property (
		pa_sync_q == $past(pa_meta_q))
		else $error("port a synchroniser skipped a stage");

	// port b pins while the port register owns them
	a_pin_zero_port: assert property (
		!pair_pwm[0] |=> port_b_pin_zero == $past(port_b_output_value_q[0]))
		else $error("pin zero does not follow port output bit");
	a_pin_one_port: assert property (
		!pair_pwm[1] |=> port_b_pin_one == $past(port_b_output_value_q[1]))
		else $error("pin one does not follow port output bit");

	// counting and wrapping
	a_pwm_down_third: assert property (
		pair_pwm[1] && step[2] && !wr_cnt[2] |=> cnt_q[2] == $past(cnt_q[2]) - 8'h01)
		else $error("pwm counter c did not decrement");
	a_pwm_down_casc_high: assert property (
		pair_pwm[0] && pair_casc[0] && step[1] |=> cnt_q[1] == $past(cnt_q[1]) - 8'h01)
		else $error("cascaded pwm high half did not decrement");
	a_pwm_wrap_third: assert property (
		pair_pwm[1] && !pair_casc[1] && step[2] && !wr_cnt[2] && cnt_q[2] == 8'h00 |=> cnt_q[2] == 8'hff)
		else $error("pwm counter c underflow did not reload 0xff");
	a_casc_wrap_full: assert property (
		pair_pwm[0] && pair_casc[0] && step[0] && {cnt_q[1], cnt_q[0]} == 16'h0000
		|=> {cnt_q[1], cnt_q[0]} == 16'hffff)
		else $error("cascaded pwm underflow did not reload 0xffff");
	a_capture_wrap_up: assert property (
		!pair_pwm[0] && !pair_casc[0] && count_up[0] && step[0] && !wr_cnt[0] && cnt_q[0] == 8'hff
		|=> cnt_q[0] == 8'h00)
		else $error("up count overflow did not wrap to zero");
	a_capture_wrap_down: assert property (
		!pair_pwm[0] && !pair_casc[0] && !count_up[0] && step[0] && !wr_cnt[0] && cnt_q[0] == 8'h00
		|=> cnt_q[0] == 8'hff)
		else $error("down count underflow did not wrap to 0xff");
	a_casc_wrap_zero: assert property (
		!pair_pwm[0] && pair_casc[0] && count_up[0] && step[0] && {cnt_q[1], cnt_q[0]} == 16'hffff
		|=> {cnt_q[1], cnt_q[0]} == 16'h0000)
		else $error("cascaded overflow did not wrap to zero");

	// waveform compare and resolution
	a_wave_at_code: assert property (
		!pair_casc[0] && cnt_q[0] <= code_q[0] |-> wave[0])
		else $error("wave low at or below duty code");
	a_wave_third_above: assert property (
		!pair_casc[1] && cnt_q[2] > code_q[2] |-> !wave[1])
		else $error("wave c high above duty code");
	a_single_eight_bit: assert property (
		!pair_casc[1] && cnt_q[2] == 8'hff && code_q[2] != 8'hff |-> !wave[1])
		else $error("single pwm wider than eight bits");
	a_res_mask_first: assert property (
		pair_casc[0] && res_first == 2'b11 && {cnt_q[1], cnt_q[0]} > {code_q[1], code_q[0]} |-> !wave[0])
		else $error("sixteen bit pwm high above code");
	a_res_twelve: assert property (
		pair_casc[1] && res_second == 2'b01 && {code_q[3], code_q[2]} <= RES_MASK_12
		&& ({cnt_q[3], cnt_q[2]} & RES_MASK_12) <= {code_q[3], code_q[2]} |-> wave[1])
		else $error("twelve bit pwm low at or below code");
	a_res_fourteen_low: assert property (
		pair_casc[0] && res_first == 2'b10 && ({cnt_q[1], cnt_q[0]} & RES_MASK_14) > {code_q[1], code_q[0]}
		|-> !wave[0])
		else $error("fourteen bit pwm high above code");
	a_over_range_second: assert property (
		pair_casc[1] && res_second == 2'b10 && {code_q[3], code_q[2]} > RES_MASK_14 |-> wave[1])
		else $error("out of range code did not hold wave c high");
	a_period_wrap: assert property (
		pair_pwm[0] && pair_casc[0] && res_first == 2'b00 && step[0]
		&& ({cnt_q[1], cnt_q[0]} & RES_MASK_10) == 16'h0000
		|=> ({cnt_q[1], cnt_q[0]} & RES_MASK_10) == RES_MASK_10)
		else $error("ten bit pwm period did not restart");

	// capture and read path
	a_shadow_read_a: assert property (
		reg_rd && reg_addr == ADDR_CNT_A && capture_active |=> reg_rdata == $past(shadow_q[0]))
		else $error("read of a did not return shadow");
	a_shadow_read_b: assert property (
		reg_rd && reg_addr == ADDR_CNT_B && capture_active |=> reg_rdata == $past(shadow_q[1]))
		else $error("read of b did not return shadow");
	a_live_read_c: assert property (
		reg_rd && reg_addr == ADDR_CNT_C |=> reg_rdata == $past(cnt_q[2]))
		else $error("read of c did not return live count");
	a_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_capture_irq_b: assert property (
		counter_second_interrupt |-> shadow_q[1] == $past(cnt_q[1]))
		else $error("capture interrupt b without shadow update");
	a_irq_after_take: assert property (
		capture_take[1] && !pair_pwm[0] |=> counter_second_interrupt)
		else $error("capture interrupt b missing after take");
	a_shared_cond: assert property (
		capture_cond |=> pending_q == 2'b11)
		else $error("capture condition not shared by a and b");
	a_pending_held: assert property (
		pending_q[1] && !step[1] |=> pending_q[1])
		else $error("capture b taken without its own step");
	a_edge_rise: assert property (
		capture_edge_select == EDGE_RISE && src_fall |-> !capture_cond)
		else $error("falling edge captured in rising mode");
	a_edge_fall: assert property (
		capture_edge_select == EDGE_FALL && src_rise |-> !capture_cond)
		else $error("rising edge captured in falling mode");
	a_src_tap_1k: assert property (
		capture_source_select == SRC_TAP_1K |-> src_now == tap_1k)
		else $error("slow tap not selected as capture source");
	a_src_pin_three: assert property (
		capture_source_select == SRC_PIN_THREE |-> src_now == pa_sync_q[1])
		else $error("pin three not selected as capture source");

	c_capture_first: cover property (counter_first_interrupt);
	c_both_capture: cover property (counter_first_interrupt && counter_second_interrupt);
	c_casc_pwm_wave: cover property (pair_casc[0] && pair_pwm[0] && $rose(port_b_pin_zero));
	c_single_pwm_high: cover property (pair_pwm[1] && !pair_casc[1] && $fell(port_b_pin_one));
	c_capture_pin_three: cover property (counter_first_interrupt && capture_source_select == SRC_PIN_THREE);

endmodule

// *** dv/capture_pin_model.sv ***
// far-side pads feeding the two port a capture inputs
`timescale 1ns/10ps
module capture_pin_model (
	input wire logic [1:0] level_req,
	output logic port_a_pin_two,
	output logic port_a_pin_three
);
	initial port_a_pin_two = 1'b0;
	initial port_a_pin_three = 1'b0;
	// pad delay puts edges 3.3 ns after the core clock rising edge
	always @(level_req) begin
		port_a_pin_two <= #3.3 level_req[0];
		port_a_pin_three <= #3.3 level_req[1];
	end
endmodule

// *** dv/counter_pwm_and_capture_tb.sv ***
// self-checking bench for the counter pwm and capture block
`timescale 1ns/10ps
module counter_pwm_and_capture_tb;
	import cnt_pwm_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [3:0] count_tick = 4'h0;
	logic tap_1k = 1'b0;
	logic tap_32k = 1'b0;
	logic [1:0] level_req = 2'h0;
	logic pa2, pa3, pb0, pb1, irq_a, irq_b;
	logic [15:0] hi0, hi1, ia, ib, code, v1, v2;
	logic [1:0] s, e;
	int res;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;

	counter_pwm_capture dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick), .tap_1k(tap_1k),
		.tap_32k(tap_32k), .port_a_pin_two(pa2), .port_a_pin_three(pa3), .port_b_pin_zero(pb0),
		.port_b_pin_one(pb1), .counter_first_interrupt(irq_a), .counter_second_interrupt(irq_b));
	capture_pin_model pins_u (.level_req(level_req), .port_a_pin_two(pa2), .port_a_pin_three(pa3));

	initial forever #4 core_clk = ~core_clk;

	task automatic end_of_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = {8'h00, reg_rdata};
	endtask

	// counts high cycles of pins and interrupts; optional noise on the 32k tap
	task automatic watch(input int n, input logic noise);
		hi0 = 0;
		hi1 = 0;
		ia = 0;
		ib = 0;
		repeat (n) begin
			@(posedge core_clk);
			if (noise) tap_32k <= 1'($urandom);
			#1;
			hi0 += pb0;
			hi1 += pb1;
			ia += irq_a;
			ib += irq_b;
		end
	endtask

	task automatic drive_src(input logic [1:0] src, input logic v);
		@(posedge core_clk);
		case (src)
			2'b11: tap_1k <= v;
			2'b10: tap_32k <= v;
			2'b01: level_req[1] <= v;
			default: level_req[0] <= v;
		endcase
	endtask

	// high cycles per period: code+1, or the whole period when code is past the range
	function automatic logic [15:0] high_time(input logic [15:0] c, input int r);
		return (c > 16'((1 << r) - 1)) ? 16'(1 << r) : c + 16'h1;
	endfunction

	initial begin
		void'($urandom(32'hae8d));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(ADDR_CONFIG_FIRST, v1);
		chk(v1, 16'(RESET_CONFIG));
		rd(ADDR_CNT_A, v1);
		chk(v1, 16'(RESET_COUNTER));
		// single pwm on pin zero, direction bit set up on purpose
		wr(ADDR_DIRECTION, 8'h0f);
		wr(ADDR_CNT_A, 8'h00);
		wr(ADDR_CONFIG_FIRST, 8'h11);
		rd(ADDR_CNT_A, v1);
		@(posedge core_clk);
		count_tick <= 4'h1;
		@(posedge core_clk);
		count_tick <= 4'h0;
		rd(ADDR_CNT_A, v2);
		chk(v1, 16'h0000);
		chk(v2, 16'h00ff);
		wr(ADDR_PORT_B_OUT, 8'h02);
		wr(ADDR_CONFIG_FIRST, 8'h00);
		code = 16'($urandom % 256);
		wr(ADDR_CNT_A, code[7:0]);
		wr(ADDR_CONFIG_SECOND, {SRC_TAP_32K, EDGE_BOTH, 4'h0});
		wr(ADDR_CONFIG_FIRST, 8'h11);
		count_tick <= 4'hf;
		watch(8, 1'b0);
		watch(256, 1'b1);
		chk(hi0, high_time(code, 8));
		chk(hi1, 16'd256);
		chk(ia + ib, 16'h0000);
		tap_32k <= 1'b0;
		// cascaded pair on pin one; last pass puts the code above the range
		for (int r = 0; r < 4; r++) begin
			res = 10 + 2 * (r % 3);
			code = (r == 3) ? 16'h0400 + 16'($urandom % 64512) : 16'($urandom % (1 << res));
			wr(ADDR_CONFIG_FIRST, 8'h00);
			wr(ADDR_CNT_C, code[7:0]);
			wr(ADDR_CNT_D, code[15:8]);
			wr(ADDR_CONFIG_SECOND, {4'h0, 2'(r % 3), 2'h0});
			wr(ADDR_CONFIG_FIRST, 8'hca);
			watch(8, 1'b0);
			watch(1 << res, 1'b0);
			chk(hi1, high_time(code, res));
			chk(hi0, 16'h0000);
		end
		// cascaded pair on pin zero with a code above the ten bit range
		code = 16'h0400 + 16'($urandom % 1024);
		wr(ADDR_CONFIG_FIRST, 8'h00);
		wr(ADDR_CNT_A, code[7:0]);
		wr(ADDR_CNT_B, code[15:8]);
		wr(ADDR_CONFIG_SECOND, 8'h00);
		wr(ADDR_CONFIG_FIRST, 8'h35);
		watch(8, 1'b0);
		watch(1024, 1'b0);
		chk(hi0, high_time(code, 10));
		chk(hi1, 16'd1024);
		chk(ia + ib, 16'h0000);
		// capture over every source and edge setting
		for (int k = 0; k < 16; k++) begin
			s = 2'(k >> 2);
			e = 2'(k);
			wr(ADDR_CONFIG_FIRST, 8'h00);
			wr(ADDR_CONFIG_SECOND, {s, e, 4'h0});
			wr(ADDR_CNT_A, 8'hff);
			wr(ADDR_CNT_B, 8'hff);
			wr(ADDR_CONFIG_FIRST, 8'h30);
			watch(8, 1'b0);
			drive_src(s, 1'b1);
			watch(12, 1'b0);
			chk(ia, 16'(e[0]));
			chk(ib, 16'(e[0]));
			drive_src(s, 1'b0);
			watch(12, 1'b0);
			chk(ia, 16'(e[1]));
			chk(ib, 16'(e[1]));
		end
		rd(ADDR_CNT_A, v1);
		watch(5, 1'b0);
		rd(ADDR_CNT_A, v2);
		chk(v2, v1);
		wr(ADDR_CONFIG_SECOND, 8'h00);
		rd(ADDR_CNT_A, v1);
		rd(ADDR_CNT_A, v2);
		chk(16'(v1 != v2), 16'h0001);
		end_of_test();
	end
endmodule
